// ===== rtl/mas_defines.svh
`ifndef MAS_DEFINES_SVH
`define MAS_DEFINES_SVH

// Register indices and byte addresses (index times four)
`define MAS_IDX_MON         5'h11
`define MAS_IDX_MASK        5'h12
`define MAS_ADDR_MON        8'h44
`define MAS_ADDR_MASK       8'h48
`define MAS_ADDR_FLAGS      8'h4c
`define MAS_ADDR_BUSY       8'h50

// Field positions
`define MAS_PIN_BIT         21
`define MAS_LOC_HI          20
`define MAS_LOC_LO          16
`define MAS_TRIG_HI         10
`define MAS_TRIG_LO         8
`define MAS_SEQD_HI         7
`define MAS_SEQD_LO         5
`define MAS_NODE_HI         4
`define MAS_NODE_LO         0

// Reset values
`define MAS_MON_RESET       22'h110000
`define MAS_MASK_RESET      22'h120000

// Trigger code and writable masks
`define MAS_TRIG_START      3'h4
`define MAS_MON_WR_MASK     22'h00ffff
`define MAS_MASK_WR_MASK    22'h00ffff

// Mask bits naming each fault flag
`define MAS_M_ACCESS        15
`define MAS_M_COMPL         12
`define MAS_M_CLOCK         10
`define MAS_M_LATCH         9
`define MAS_M_WDOG          8
`define MAS_M_SLIP          7
`define MAS_M_FRAME         6
`define MAS_M_OPEN          3
`define MAS_M_SHORT         2
`define MAS_M_TEMP          0

`endif

// ===== rtl/mas_pkg.sv
package mas_pkg;

  // Node codes for the diagnostic converter multiplexer
  typedef enum logic [4:0] {
    MAS_NODE_TEMP    = 5'b00000,
    MAS_NODE_EXTREF  = 5'b00011,
    MAS_NODE_BANDREF = 5'b00100,
    MAS_NODE_REFERENCE_GROUND_NODE  = 5'b11000,
    MAS_NODE_AGND    = 5'b11001,
    MAS_NODE_DGND    = 5'b11010,
    MAS_NODE_REFERENCE_OUTPUT_NODE  = 5'b11111
  } mas_node_e;

  // Write channel states
  typedef enum logic [1:0] {
    MAS_W_IDLE = 2'b00,
    MAS_W_RESP = 2'b01
  } mas_wstate_e;

  typedef logic [21:0] mas_reg_t;

endpackage : mas_pkg

// ===== rtl/mas_node_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "mas_defines.svh"

// Maps a node-select code onto the one-hot multiplexer selects
module mas_node_decode
  import mas_pkg::*;
(
  input  wire logic [4:0] node_code,
  input  wire logic       ext_ref_buf_en,
  output logic            sel_temp,
  output logic            sel_ext_ref,
  output logic            sel_band_ref,
  output logic            sel_ref_gnd,
  output logic            sel_agnd,
  output logic            sel_dgnd,
  output logic            sel_ref_out,
  output logic            node_valid
);

  // Listed codes only; the external input counts only with its buffer on
  assign sel_temp     = (node_code == MAS_NODE_TEMP);
  assign sel_ext_ref  = (node_code == MAS_NODE_EXTREF) && ext_ref_buf_en;
  assign sel_band_ref = (node_code == MAS_NODE_BANDREF);
  assign sel_ref_gnd  = (node_code == MAS_NODE_REFERENCE_GROUND_NODE);
  assign sel_agnd     = (node_code == MAS_NODE_AGND);
  assign sel_dgnd     = (node_code == MAS_NODE_DGND);
  assign sel_ref_out  = (node_code == MAS_NODE_REFERENCE_OUTPUT_NODE);
  assign node_valid   = sel_temp | sel_ext_ref | sel_band_ref | sel_ref_gnd
                      | sel_agnd | sel_dgnd | sel_ref_out;

endmodule : mas_node_decode
`default_nettype wire

// ===== rtl/mas_regs.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mas_defines.svh"

module mas_regs
  import mas_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Fault flags from the diagnostic logic, bit positions as the mask
  input  wire logic [15:0] fault_flags,
  input  wire logic        ext_ref_buf_en,
  input  wire logic        conv_busy,
  // Converter side
  output logic             conv_start,
  output logic [4:0]       monitor_node_select,
  output logic [6:0]       node_onehot,
  output logic             node_valid,
  output logic [15:0]      flag_mask,
  // Open-drain alarm pin, active low
  input  wire logic        alarm_n_in,
  output logic             alarm_n_out,
  output logic             alarm_n_oe
);

  // Bit positions that carry a real flag; others never reach the pin
  localparam logic [15:0] FLAG_USED = 16'h97cd;

  mas_reg_t    mon_reg;
  mas_reg_t    mon_next;
  mas_reg_t    mask_reg;
  mas_reg_t    mask_next;
  logic        conv_start_reg;
  logic        alarm_reg;
  logic        alarm_next;
  mas_wstate_e wstate_reg;
  logic [7:0]  awaddr_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_held_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Merge a 32-bit write into a 22-bit register under byte enables
  function automatic mas_reg_t merge_write(input mas_reg_t old_val,
                                           input logic [31:0] data,
                                           input logic [3:0] strb,
                                           input mas_reg_t wr_mask);
    mas_reg_t lane;
    lane = {{6{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_write = (old_val & ~(lane & wr_mask)) | (data[21:0] & lane & wr_mask);
  endfunction : merge_write

  // Read-only top fields: live pin status and own location
  function automatic logic [31:0] read_word(input mas_reg_t val,
                                            input logic [4:0] loc,
                                            input logic pin);
    read_word = {10'h000, pin, loc, val[15:0]};
  endfunction : read_word

  // Write address/data capture, taken in either order
  wire         aw_take   = s_axi_awvalid && s_axi_awready;
  wire         w_take    = s_axi_wvalid && s_axi_wready;
  wire         have_aw   = aw_held_reg || aw_take;
  wire         have_w    = w_held_reg || w_take;
  wire  [7:0]  wr_addr   = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire  [31:0] wr_data   = w_held_reg ? wdata_reg : s_axi_wdata;
  wire  [3:0]  wr_strb   = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire         wr_fire   = (wstate_reg == MAS_W_IDLE) && have_aw && have_w;
  wire         wr_mon    = wr_fire && (wr_addr == `MAS_ADDR_MON);
  wire         wr_mask   = wr_fire && (wr_addr == `MAS_ADDR_MASK);
  wire         wr_ok     = (wr_addr == `MAS_ADDR_MON) || (wr_addr == `MAS_ADDR_MASK);

  assign s_axi_awready = (wstate_reg == MAS_W_IDLE) && !aw_held_reg;
  assign s_axi_wready  = (wstate_reg == MAS_W_IDLE) && !w_held_reg;
  assign s_axi_bvalid  = (wstate_reg == MAS_W_RESP);
  assign s_axi_bresp   = bresp_reg;

  // Register next values; the trigger field keeps the written code and only the start pulse acts once
  always_comb
  begin
    mon_next  = mon_reg;
    mask_next = mask_reg;
    if (wr_mon)
    begin
      mon_next = merge_write(mon_reg, wr_data, wr_strb, `MAS_MON_WR_MASK);
    end
    if (wr_mask)
    begin
      mask_next = merge_write(mask_reg, wr_data, wr_strb, `MAS_MASK_WR_MASK);
    end
  end

  // One start pulse on a write that lands trigger code 100
  wire start_hit = wr_mon && wr_strb[1] &&
                   (wr_data[`MAS_TRIG_HI:`MAS_TRIG_LO] == `MAS_TRIG_START);

  // Write channel bookkeeping
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wstate_reg  <= MAS_W_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bresp_reg   <= 2'b00;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      case (wstate_reg)
        MAS_W_IDLE:
        begin
          if (wr_fire)
          begin
            wstate_reg  <= MAS_W_RESP;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bresp_reg   <= wr_ok ? 2'b00 : 2'b10;
          end
          else
          begin
            aw_held_reg <= have_aw;
            w_held_reg  <= have_w;
          end
        end
        MAS_W_RESP:
        begin
          if (s_axi_bready)
          begin
            wstate_reg <= MAS_W_IDLE;
          end
        end
        default:
        begin
          wstate_reg <= MAS_W_IDLE;
        end
      endcase
    end
  end

  // Configuration registers and start pulse
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mon_reg        <= `MAS_MON_RESET;
      mask_reg       <= `MAS_MASK_RESET;
      conv_start_reg <= 1'b0;
    end
    else
    begin
      mon_reg        <= mon_next;
      mask_reg       <= mask_next;
      conv_start_reg <= start_hit;
    end
  end

  // Trigger field reads back last code written; not cleared by hardware
  assign conv_start          = conv_start_reg;
  assign monitor_node_select = mon_reg[`MAS_NODE_HI:`MAS_NODE_LO];
  assign flag_mask           = mask_reg[15:0];

  // Node decode; unlisted codes leave node_valid low so result is zero
  mas_node_decode i_mas_node_decode (
    .node_code      (mon_reg[`MAS_NODE_HI:`MAS_NODE_LO]),
    .ext_ref_buf_en (ext_ref_buf_en),
    .sel_temp       (node_onehot[0]),
    .sel_ext_ref    (node_onehot[1]),
    .sel_band_ref   (node_onehot[2]),
    .sel_ref_gnd    (node_onehot[3]),
    .sel_agnd       (node_onehot[4]),
    .sel_dgnd       (node_onehot[5]),
    .sel_ref_out    (node_onehot[6]),
    .node_valid     (node_valid)
  );

  // Unmasked flags drive the pin; masked flags stay visible in status
  wire [15:0] live_flags = fault_flags & FLAG_USED & ~mask_reg[15:0];
  assign alarm_next = |live_flags;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      alarm_reg <= 1'b0;
    end
    else
    begin
      alarm_reg <= alarm_next;
    end
  end

  // Open drain: pull low only while in alarm
  assign alarm_n_out = 1'b0;
  assign alarm_n_oe  = alarm_reg;

  // Read channel, answer one cycle after address taken
  // Pin status is taken from the wire itself, so another driver pulling the
  // shared line low shows too; a low (alarmed) pin reads as one, which keeps
  // an idle pin at the documented reset value of both registers
  wire pin_level = !alarm_n_in;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  wire [31:0] rd_word =
    (s_axi_araddr == `MAS_ADDR_MON)   ? read_word(mon_reg, `MAS_IDX_MON, pin_level) :
    (s_axi_araddr == `MAS_ADDR_MASK)  ? read_word(mask_reg, `MAS_IDX_MASK, pin_level) :
    (s_axi_araddr == `MAS_ADDR_FLAGS) ? {16'h0000, fault_flags} :
    (s_axi_araddr == `MAS_ADDR_BUSY)  ? {31'h0, conv_busy} : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr == `MAS_ADDR_MON) || (s_axi_araddr == `MAS_ADDR_MASK) ||
               (s_axi_araddr == `MAS_ADDR_FLAGS) || (s_axi_araddr == `MAS_ADDR_BUSY);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
    end
    else if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks
  start_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    start_hit |=> conv_start ##1 !conv_start)
    else $error("start pulse not single cycle after trigger write");

  start_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    conv_start |-> $past(wr_mon))
    else $error("start pulse without a setup write");

  alarm_any_a: assert property (@(posedge sys_clk) disable iff (rst)
    (|(fault_flags & FLAG_USED & ~mask_reg[15:0])) |=> alarm_n_oe)
    else $error("unmasked flag did not pull alarm low");

  alarm_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((fault_flags & ~mask_reg[15:0]) == 16'h0000) |=> !alarm_n_oe)
    else $error("masked flags still pulled alarm");

  access_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mask_reg[`MAS_M_ACCESS] && fault_flags == 16'h8000) |=> !alarm_n_oe)
    else $error("masked access flag reached alarm");

  temp_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!mask_reg[`MAS_M_TEMP] && fault_flags[`MAS_M_TEMP]) |=> alarm_n_oe)
    else $error("over temperature did not raise alarm");

  read_loc_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_axi_arvalid && !rvalid_reg && s_axi_araddr == `MAS_ADDR_MASK) |=>
      (rvalid_reg && rdata_reg[20:16] == 5'h12))
    else $error("mask register location field wrong");

  read_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_axi_arvalid && !rvalid_reg && s_axi_araddr == `MAS_ADDR_MON) |=>
      (rdata_reg[21] == !$past(alarm_n_in)))
    else $error("pin status not returned in bit 21");

  mon_loc_a: assert property (@(posedge sys_clk) disable iff (rst)
    (s_axi_arvalid && !rvalid_reg && s_axi_araddr == `MAS_ADDR_MON) |=>
      (rvalid_reg && rdata_reg[20:16] == 5'h11))
    else $error("setup register location field wrong");

  node_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(monitor_node_select inside {5'h00, 5'h03, 5'h04, 5'h18, 5'h19, 5'h1a, 5'h1f}) |->
      (!node_valid && node_onehot == 7'h00))
    else $error("unlisted node selected a source");

  ref_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    (monitor_node_select == 5'b11111) |-> (node_valid && node_onehot == 7'h40))
    else $error("reference output node not selected");

  ext_ref_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    (monitor_node_select == 5'b00011 && ext_ref_buf_en) |-> (node_valid && node_onehot == 7'h02))
    else $error("external reference missing with buffer on");

  open_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
    (mask_reg[`MAS_M_OPEN] && fault_flags == 16'h0008) |=> !alarm_n_oe)
    else $error("masked open circuit flag reached alarm");

  ext_ref_a: assert property (@(posedge sys_clk) disable iff (rst)
    (monitor_node_select == 5'b00011 && !ext_ref_buf_en) |-> !node_valid)
    else $error("external reference valid without buffer");

endmodule : mas_regs
`default_nettype wire

// ===== dv/mas_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// Converter and pulled-up open-drain alarm line beside the register bank
module mas_far_model #(
  parameter int BUSY_CYCLES = 40
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic conv_start,
  input  wire logic alarm_n_out,
  input  wire logic alarm_n_oe,
  output logic      alarm_n_in,
  output logic      conv_busy
);
  int cnt;

  // Pull-up wins whenever nobody drives the pin, so idle reads high
  assign alarm_n_in = alarm_n_oe ? alarm_n_out : 1'b1;
  assign conv_busy  = (cnt != 0);

  // A start pulse keeps the converter busy for a fixed span
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt <= 0;
    else if (conv_start)
      cnt <= BUSY_CYCLES;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule : mas_far_model

`default_nettype wire

// ===== dv/monitor_adc_setup_and_alarm_mask_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module monitor_adc_setup_and_alarm_mask_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] fault_flags = 16'h0;
  logic [15:0] flag_mask;
  logic        ext_ref_buf_en = 1'b0;
  logic        conv_busy, conv_start, node_valid, alarm_n_in, alarm_n_out, alarm_n_oe;
  logic [4:0]  monitor_node_select;
  logic [6:0]  node_onehot;
  logic [6:0]  exp_hot;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          n_errors = 0, n_checks = 0, cycles = 0, starts = 0;
  // Listed node codes, two unlisted ones, and the one-hot select each should give
  logic [4:0]  codes [9] = '{5'h00, 5'h03, 5'h04, 5'h18, 5'h19, 5'h1a, 5'h1f, 5'h01, 5'h1e};
  logic [6:0]  hots [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00, 7'h00};
  int          used [10] = '{15, 12, 10, 9, 8, 7, 6, 3, 2, 0};

  mas_regs i_mas_regs (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fault_flags, .ext_ref_buf_en, .conv_busy, .conv_start,
    .monitor_node_select, .node_onehot, .node_valid, .flag_mask, .alarm_n_in, .alarm_n_out,
    .alarm_n_oe);

  mas_far_model i_mas_far_model (.sys_clk, .rst, .conv_start, .alarm_n_out, .alarm_n_oe,
    .alarm_n_in, .conv_busy);

  always #5 sys_clk = ~sys_clk;

  // Counts start pulses and cuts a hang short; the run needs about 400 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (conv_start === 1'b1)
      starts++;
    if (cycles == 5000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // Ready is sampled mid-cycle; inputs and registers only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on, w_on, aw_hit, w_hit, b_hit;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    b_hit = 1'b0;
    while (aw_on || w_on)
    begin
      @(negedge sys_clk);
      aw_hit = aw_on && (s_axi_awready === 1'b1);
      w_hit = w_on && (s_axi_wready === 1'b1);
      @(posedge sys_clk);
      if (aw_hit)
        s_axi_awvalid <= 1'b0;
      if (w_hit)
        s_axi_wvalid <= 1'b0;
      aw_on = aw_on && !aw_hit;
      w_on = w_on && !w_hit;
    end
    while (!b_hit)
    begin
      @(negedge sys_clk);
      b_hit = (s_axi_bvalid === 1'b1);
      rsp = s_axi_bresp;
      @(posedge sys_clk);
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    logic hit;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hit = 1'b0;
    while (!hit)
    begin
      @(negedge sys_clk);
      hit = (s_axi_arready === 1'b1);
      @(posedge sys_clk);
    end
    s_axi_arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit)
    begin
      @(negedge sys_clk);
      hit = (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
    end
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    `CHK(rd, e)
    `CHK(rsp, 2'b00)
  endtask : rdchk

  // Host writes only the start code to the setup register and keeps its bits 7:5 at zero throughout
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(8'h44, 32'h0011_0000);
    rdchk(8'h48, 32'h0012_0000);
    `CHK({flag_mask, alarm_n_oe, monitor_node_select}, 22'h0)
    `CHK(alarm_n_out, 1'b0)
    wr(8'h44, 32'h003f_0404);
    `CHK(rsp, 2'b00)
    idle(2);
    `CHK(starts, 1)
    `CHK(monitor_node_select, 5'h04)
    rdchk(8'h44, 32'h0011_0404);
    rdchk(8'h50, 32'h0000_0001);
    // Every listed node code and two unlisted ones, with the reference buffer off and then on
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 9; i++)
      begin
        ext_ref_buf_en <= e[0];
        wr(8'h44, {16'h0, 8'h04, 3'b000, codes[i]});
        idle(2);
        exp_hot = (i == 1 && e == 0) ? 7'h00 : hots[i];
        `CHK(monitor_node_select, codes[i])
        `CHK(node_onehot, exp_hot)
        `CHK(node_valid, exp_hot != 7'h00)
      end
    `CHK(starts, 19)
    // One flag at a time: unmasked, with all other bits masked, masked by its own bit
    foreach (used[i])
    begin
      fault_flags <= 16'h1 << used[i];
      wr(8'h48, 32'h0);
      idle(3);
      `CHK(alarm_n_oe, 1'b1)
      rdchk(8'h48, 32'h0032_0000);
      wr(8'h48, 32'h0000_ffff ^ (32'h1 << used[i]));
      idle(3);
      `CHK(alarm_n_oe, 1'b1)
      wr(8'h48, 32'h1 << used[i]);
      idle(3);
      `CHK(alarm_n_oe, 1'b0)
      `CHK(flag_mask, 16'h1 << used[i])
      rdchk(8'h48, 32'h0012_0000 | (32'h1 << used[i]));
      rdchk(8'h4c, 32'h1 << used[i]);
    end
    // Unmapped address is refused and leaves the mask alone
    rd_reg(8'h04);
    `CHK({rd, rsp}, 34'h2)
    wr(8'h04, 32'h0000_ffff);
    `CHK(rsp, 2'b10)
    rdchk(8'h48, 32'h0012_0001);
    // Second reset in mid-run returns both registers to their reset values
    fault_flags <= 16'h0;
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rdchk(8'h48, 32'h0012_0000);
    rdchk(8'h44, 32'h0011_0000);
    test_done();
  end
endmodule : monitor_adc_setup_and_alarm_mask_tb

`default_nettype wire
